// [design/frrc_pkg.sv]
package frrc_pkg;

    localparam int unsigned NUM_CHAN = 8;

    // command codes on the register port
    localparam logic [7:0] CMD_OV_MASK = 8'hd2;
    localparam logic [7:0] CMD_UV_MASK = 8'hd3;
    localparam logic [7:0] CMD_RETRY_LIMIT = 8'hf7;
    localparam logic [7:0] CMD_RETRY_INTERVAL = 8'hdb;
    localparam logic [7:0] CMD_RESTART_HOLD = 8'hec;

    // reset values
    localparam logic [7:0] OV_MASK_RST = 8'h00;
    localparam logic [7:0] UV_MASK_RST = 8'h00;
    localparam logic [2:0] RETRY_LIMIT_RST = 3'h0;
    localparam logic [15:0] RETRY_INTERVAL_RST = 16'h0000;
    localparam logic [15:0] RESTART_HOLD_RST = 16'h0000;

    // field layout
    localparam int unsigned RETRY_LIMIT_MSB = 2;
    localparam logic [2:0] RETRY_LIMIT_NONE = 3'h0;
    localparam logic [2:0] RETRY_LIMIT_FOREVER = 3'h7;
    localparam int unsigned L11_EXP_LSB = 11;
    localparam int unsigned L11_MANT_MSB = 10;

    // timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SHARED_CLK_HZ = 100_000;
    localparam int unsigned DELAY_UNIT_US = 200;
    localparam int unsigned DELAY_UNITS_PER_MS = 1000 / DELAY_UNIT_US;
    localparam int unsigned EDGES_PER_UNIT = SHARED_CLK_HZ / 1_000_000 * 0
        + (SHARED_CLK_HZ / 1000) * DELAY_UNIT_US / 1000;
    localparam logic [7:0] EDGES_PER_UNIT_C = 8'(EDGES_PER_UNIT);
    localparam int unsigned MAX_DELAY_MS = 13_100;
    localparam logic [15:0] MAX_DELAY_UNITS = 16'(MAX_DELAY_MS * DELAY_UNITS_PER_MS);
    localparam int unsigned QUIET_TIME_S = 6;
    localparam int unsigned QUIET_UNITS = QUIET_TIME_S * 1_000_000 / DELAY_UNIT_US;
    localparam int unsigned MIN_OFF_US = 10;
    localparam int unsigned MIN_OFF_CYC = (MIN_OFF_US * (CLK_HZ / 1_000_000));
    localparam logic [10:0] MIN_OFF_CYC_C = 11'(MIN_OFF_CYC);

endpackage : frrc_pkg

// [design/frrc_cfg_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface frrc_cfg_if;
    logic unit_tick;
    logic [2:0] retry_limit;
    logic [15:0] retry_units;
    logic clear_all;
    modport ctrl (output unit_tick, output retry_limit, output retry_units, output clear_all);
    modport chan (input unit_tick, input retry_limit, input retry_units, input clear_all);
endinterface : frrc_cfg_if
`default_nettype wire

// [design/frrc_delay_conv.sv]
`timescale 1ns/1ps
`default_nettype none
module frrc_delay_conv
    import frrc_pkg::*;
(
    input wire logic [15:0] l11,
    output logic [15:0] units
);
    logic signed [4:0] expo;
    logic signed [10:0] mant;
    logic [13:0] prod;
    logic [47:0] wide;
    logic [4:0] shr;

    always_comb begin
        expo = l11[15:L11_EXP_LSB];
        mant = l11[L11_MANT_MSB:0];
        shr = 5'h00;
        prod = 14'h0000;
        wide = 48'h0;
        if (mant > 0) begin
            prod = 14'(mant[9:0]) * 14'(DELAY_UNITS_PER_MS);
        end
        if (expo >= 0) begin
            wide = {34'h0, prod} << expo[3:0];
        end else begin
            shr = 5'(-expo);
            // add half an lsb before shifting for nearest rounding
            wide = ({34'h0, prod} + ((48'h1 << shr) >> 1)) >> shr;
        end
        if (wide > 48'(MAX_DELAY_UNITS)) begin
            units = MAX_DELAY_UNITS;
        end else begin
            units = wide[15:0];
        end
    end
endmodule : frrc_delay_conv
`default_nettype wire

// [design/frrc_chan_retry.sv]
`timescale 1ns/1ps
`default_nettype none
module frrc_chan_retry
    import frrc_pkg::*;
#(
    parameter int unsigned QUIET_LIMIT = QUIET_UNITS
) (
    input wire logic clk,
    input wire logic rst_b,
    frrc_cfg_if.chan cfg,
    input wire logic faulted_off,
    input wire logic clear_req,
    output logic retry_go_q,
    output logic exhausted_q
);
    typedef enum logic [0:0] {RT_IDLE, RT_WAIT} frrc_rt_state_t;
    frrc_rt_state_t state_q;
    logic [2:0] count_q;
    logic [15:0] wait_q;
    logic [15:0] quiet_q;
    logic quiet_done;
    logic clear;
    logic allowed;

    assign quiet_done = (quiet_q >= 16'(QUIET_LIMIT)) && (state_q == RT_IDLE);
    assign clear = clear_req | cfg.clear_all | quiet_done;
    assign allowed = (cfg.retry_limit == RETRY_LIMIT_FOREVER)
        || ((cfg.retry_limit != RETRY_LIMIT_NONE) && (count_q < cfg.retry_limit));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            quiet_q <= 16'h0000;
        end else if (faulted_off || state_q == RT_WAIT || quiet_done) begin
            quiet_q <= 16'h0000;
        end else if (cfg.unit_tick) begin
            quiet_q <= quiet_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= RT_IDLE;
            wait_q <= 16'h0000;
            count_q <= 3'h0;
            retry_go_q <= 1'b0;
        end else begin
            retry_go_q <= 1'b0;
            unique case (state_q)
                RT_IDLE: begin
                    if (faulted_off && allowed) begin
                        state_q <= RT_WAIT;
                        wait_q <= 16'h0000;
                        // an unlimited setting never needs the count
                        if (cfg.retry_limit != RETRY_LIMIT_FOREVER) begin
                            count_q <= count_q + 3'h1;
                        end
                    end else if (clear) begin
                        count_q <= 3'h0;
                    end
                end
                RT_WAIT: begin
                    if (clear_req || cfg.clear_all) begin
                        state_q <= RT_IDLE;
                        count_q <= 3'h0;
                    end else if (wait_q >= cfg.retry_units) begin
                        state_q <= RT_IDLE;
                        retry_go_q <= 1'b1;
                    end else if (cfg.unit_tick) begin
                        wait_q <= wait_q + 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            exhausted_q <= 1'b0;
        end else if (state_q == RT_IDLE && faulted_off && !allowed) begin
            exhausted_q <= 1'b1; // set wins over a same-cycle clear
        end else if (clear) begin
            exhausted_q <= 1'b0;
        end
    end
endmodule : frrc_chan_retry
`default_nettype wire

// [design/frrc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module frrc_top
    import frrc_pkg::*;
#(
    parameter int unsigned QUIET_LIMIT = QUIET_UNITS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic shared_timebase_clock,
    input wire logic wr_en,
    input wire logic [7:0] wr_cmd,
    input wire logic [15:0] wr_data,
    input wire logic [7:0] rd_cmd,
    output logic [15:0] rd_data_q,
    output logic rd_hit_q,
    input wire logic [7:0] ov_fault,
    input wire logic [7:0] uv_fault,
    input wire logic [7:0] faulted_off,
    input wire logic [7:0] control_pin,
    input wire logic [7:0] operation_on,
    output logic vin_en_out_q,
    output logic vin_en_oe_n_q,
    output logic [7:0] retry_go_q,
    output logic [7:0] retry_exhausted_q,
    output logic [7:0] restart_hold_q
);
    frrc_cfg_if cfg ();

    logic [7:0] ov_mask_q;
    logic [7:0] uv_mask_q;
    logic [2:0] retry_limit_q;
    logic [15:0] retry_interval_q;
    logic [15:0] restart_hold_time_q;
    logic clear_all_q;
    logic [15:0] retry_units;
    logic [15:0] restart_units;
    logic [15:0] retry_units_q;
    logic [15:0] restart_units_q;

    // one strobe decode shared by the register writes and the count clear
    function automatic logic wr_hit(input logic en, input logic [7:0] cmd,
            input logic [7:0] code);
        return en && (cmd == code);
    endfunction : wr_hit

    // a level change counts once the last two sync stages agree on it
    function automatic logic settled_edge(input logic [2:0] stages, input logic lvl,
            input logic to_high);
        return (stages[1] == stages[2]) && (stages[2] == to_high) && (lvl != to_high);
    endfunction : settled_edge

    // register writes, one block per register; unknown codes touch nothing
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ov_mask_q <= OV_MASK_RST;
        end else if (wr_hit(wr_en, wr_cmd, CMD_OV_MASK)) begin
            ov_mask_q <= wr_data[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            uv_mask_q <= UV_MASK_RST;
        end else if (wr_hit(wr_en, wr_cmd, CMD_UV_MASK)) begin
            uv_mask_q <= wr_data[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            retry_limit_q <= RETRY_LIMIT_RST;
        end else if (wr_hit(wr_en, wr_cmd, CMD_RETRY_LIMIT)) begin
            retry_limit_q <= wr_data[RETRY_LIMIT_MSB:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            retry_interval_q <= RETRY_INTERVAL_RST;
        end else if (wr_hit(wr_en, wr_cmd, CMD_RETRY_INTERVAL)) begin
            retry_interval_q <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            restart_hold_time_q <= RESTART_HOLD_RST;
        end else if (wr_hit(wr_en, wr_cmd, CMD_RESTART_HOLD)) begin
            restart_hold_time_q <= wr_data;
        end
    end

    // counts clear one cycle after the limit write lands
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clear_all_q <= 1'b0;
        end else begin
            clear_all_q <= wr_hit(wr_en, wr_cmd, CMD_RETRY_LIMIT);
        end
    end

    // readback returns the stored word, never the converted one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_q <= 16'h0000;
            rd_hit_q <= 1'b0;
        end else begin
            rd_hit_q <= 1'b1;
            unique case (rd_cmd)
                CMD_OV_MASK: rd_data_q <= {8'h00, ov_mask_q};
                CMD_UV_MASK: rd_data_q <= {8'h00, uv_mask_q};
                CMD_RETRY_LIMIT: rd_data_q <= {13'h0000, retry_limit_q};
                CMD_RETRY_INTERVAL: rd_data_q <= retry_interval_q;
                CMD_RESTART_HOLD: rd_data_q <= restart_hold_time_q;
                default: begin
                    rd_data_q <= 16'h0000;
                    rd_hit_q <= 1'b0;
                end
            endcase
        end
    end

    // input enable pull-down: open drain, enable low while pulling
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vin_en_out_q <= 1'b0;
            vin_en_oe_n_q <= 1'b1;
        end else begin
            vin_en_out_q <= 1'b0;
            vin_en_oe_n_q <= ~(|((ov_fault & ov_mask_q) | (uv_fault & uv_mask_q)));
        end
    end

    // shared timebase: three-stage sync, level accepted when stages agree
    logic [2:0] tb_sync_q;
    logic tb_lvl_q;
    logic [7:0] tb_edges_q;
    logic unit_tick_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tb_sync_q <= 3'h0;
        end else begin
            tb_sync_q <= {tb_sync_q[1:0], shared_timebase_clock};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tb_lvl_q <= 1'b0;
        end else if (tb_sync_q[1] == tb_sync_q[2]) begin
            tb_lvl_q <= tb_sync_q[2];
        end
    end

    // the internal oscillator never times these delays; no edges, no ticks
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tb_edges_q <= 8'h00;
            unit_tick_q <= 1'b0;
        end else begin
            unit_tick_q <= 1'b0;
            if (settled_edge(tb_sync_q, tb_lvl_q, 1'b1)) begin
                if (tb_edges_q >= EDGES_PER_UNIT_C - 8'h01) begin
                    tb_edges_q <= 8'h00;
                    unit_tick_q <= 1'b1;
                end else begin
                    tb_edges_q <= tb_edges_q + 8'h01;
                end
            end
        end
    end

    frrc_delay_conv u_retry_conv (
        .l11(retry_interval_q),
        .units(retry_units)
    );

    frrc_delay_conv u_restart_conv (
        .l11(restart_hold_time_q),
        .units(restart_units)
    );

    assign cfg.unit_tick = unit_tick_q;
    assign cfg.retry_limit = retry_limit_q;
    // registered so the variable shifter stays out of eight compare paths
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            retry_units_q <= 16'h0000;
        end else begin
            retry_units_q <= retry_units;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            restart_units_q <= 16'h0000;
        end else begin
            restart_units_q <= restart_units;
        end
    end

    assign cfg.retry_units = retry_units_q;
    assign cfg.clear_all = clear_all_q;

    // per-channel control pin handling and retry
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        logic [2:0] ctl_sync_q;
        logic ctl_lvl_q;
        logic ctl_rise;
        logic ctl_fall;
        logic op_q;
        logic [10:0] off_cyc_q;
        logic [15:0] off_units_q;

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                // start at the on level so leaving reset makes no false rise
                ctl_sync_q <= 3'h7;
            end else begin
                ctl_sync_q <= {ctl_sync_q[1:0], control_pin[ch]};
            end
        end

        assign ctl_rise = settled_edge(ctl_sync_q, ctl_lvl_q, 1'b1);
        assign ctl_fall = settled_edge(ctl_sync_q, ctl_lvl_q, 1'b0);

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                ctl_lvl_q <= 1'b1;
                op_q <= 1'b0;
            end else begin
                if (ctl_sync_q[1] == ctl_sync_q[2]) begin
                    ctl_lvl_q <= ctl_sync_q[2];
                end
                op_q <= operation_on[ch];
            end
        end

        // off time, in clock cycles for the short check and in units for the hold
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                off_cyc_q <= 11'h000;
                off_units_q <= 16'h0000;
            end else if (ctl_fall) begin
                off_cyc_q <= 11'h000;
                off_units_q <= 16'h0000;
            end else if (!ctl_lvl_q || restart_hold_q[ch]) begin
                if (off_cyc_q < MIN_OFF_CYC_C) begin
                    off_cyc_q <= off_cyc_q + 11'h001;
                end
                if (unit_tick_q && off_units_q != 16'hffff) begin
                    off_units_q <= off_units_q + 16'h0001;
                end
            end
        end

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                restart_hold_q[ch] <= 1'b0;
            end else if (ctl_fall) begin
                restart_hold_q[ch] <= 1'b0;
            end else if (ctl_rise) begin
                restart_hold_q[ch] <= (restart_hold_time_q != 16'h0000)
                    && (off_cyc_q >= MIN_OFF_CYC_C)
                    && (off_units_q < restart_units_q);
            end else if (restart_hold_q[ch] && off_units_q >= restart_units_q) begin
                restart_hold_q[ch] <= 1'b0;
            end
        end

        frrc_chan_retry #(
            .QUIET_LIMIT(QUIET_LIMIT)
        ) u_retry (
            .clk(clk),
            .rst_b(rst_b),
            .cfg(cfg.chan),
            .faulted_off(faulted_off[ch]),
            .clear_req(ctl_rise || (operation_on[ch] && !op_q)),
            .retry_go_q(retry_go_q[ch]),
            .exhausted_q(retry_exhausted_q[ch])
        );
    end

endmodule : frrc_top
`default_nettype wire

// [test/frrc_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module frrc_monitor
    import frrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [7:0] wr_cmd,
    input wire logic [15:0] wr_data,
    input wire logic [7:0] rd_cmd,
    input wire logic [15:0] rd_data_q,
    input wire logic rd_hit_q,
    input wire logic [7:0] ov_fault,
    input wire logic [7:0] uv_fault,
    input wire logic [7:0] faulted_off,
    input wire logic vin_en_out_q,
    input wire logic vin_en_oe_n_q,
    input wire logic [7:0] retry_go_q,
    input wire logic [7:0] retry_exhausted_q,
    input wire logic [7:0] restart_hold_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] ovm_q;
    logic [7:0] uvm_q;
    logic [2:0] lim_q;
    logic [15:0] hold_q;
    // shadow registers, updated on the same edge as the design's
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ovm_q <= OV_MASK_RST;
            uvm_q <= UV_MASK_RST;
            lim_q <= RETRY_LIMIT_RST;
            hold_q <= RESTART_HOLD_RST;
        end else if (wr_en) begin
            case (wr_cmd)
                CMD_OV_MASK: ovm_q <= wr_data[7:0];
                CMD_UV_MASK: uvm_q <= wr_data[7:0];
                CMD_RETRY_LIMIT: lim_q <= wr_data[2:0];
                CMD_RESTART_HOLD: hold_q <= wr_data;
                default: ;
            endcase
        end
    end
    AST_OV_PULL: assert property ((ov_fault & ovm_q) != 8'h00 |=> !vin_en_oe_n_q)
        else $error("ov fault left enable free");
    AST_UV_PULL: assert property ((uv_fault & uvm_q) != 8'h00 |=> !vin_en_oe_n_q)
        else $error("uv fault left enable free");
    AST_NO_PULL: assert property ((ov_fault & ovm_q | uv_fault & uvm_q) == 8'h00 |=> vin_en_oe_n_q)
        else $error("enable pulled without masked fault");
    AST_DRIVE_LOW: assert property (!vin_en_oe_n_q |-> !vin_en_out_q)
        else $error("enable driven high");
    AST_LIM_RD: assert property (rd_cmd == CMD_RETRY_LIMIT |=>
        rd_hit_q && rd_data_q == {13'h0000, $past(lim_q)}) else $error("limit read wrong");
    AST_HOLD_RD: assert property (rd_cmd == CMD_RESTART_HOLD |=> rd_data_q == $past(hold_q))
        else $error("hold read wrong");
    AST_GO_PULSE: assert property ((retry_go_q & $past(retry_go_q)) == 8'h00)
        else $error("retry pulse too long");
    AST_LIM0: assert property (lim_q == RETRY_LIMIT_NONE && faulted_off != 8'h00 |->
        ##[1:3] retry_exhausted_q != 8'h00) else $error("limit zero allowed retry");
    AST_LIM_CLR: assert property (wr_en && wr_cmd == CMD_RETRY_LIMIT && faulted_off == 8'h00
        ##1 faulted_off == 8'h00 |=> retry_exhausted_q == 8'h00) else $error("counts kept");
    AST_HOLD_OFF: assert property (hold_q == 16'h0000 && !restart_hold_q |=> !restart_hold_q)
        else $error("stretch with zero hold");
endmodule : frrc_monitor
bind frrc_top frrc_monitor u_monitor (.clk, .rst_b, .wr_en, .wr_cmd, .wr_data, .rd_cmd,
    .rd_data_q, .rd_hit_q, .ov_fault, .uv_fault, .faulted_off, .vin_en_out_q,
    .vin_en_oe_n_q, .retry_go_q, .retry_exhausted_q, .restart_hold_q);
`default_nettype wire

// [test/frrc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module frrc_host
    import frrc_pkg::*;
(
    input wire logic clk,
    input wire logic [15:0] rd_data_q,
    input wire logic rd_hit_q,
    output logic wr_en,
    output logic [7:0] wr_cmd,
    output logic [15:0] wr_data,
    output logic [7:0] rd_cmd
);
    initial begin
        wr_en = 1'b0;
        wr_cmd = 8'h00;
        wr_data = 16'h0000;
        rd_cmd = 8'h00;
    end
    // random idle gap models a slow host
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        repeat ($urandom_range(2)) @(posedge clk);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_cmd <= c;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_data <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic h);
        @(posedge clk);
        rd_cmd <= c;
        repeat (2) @(posedge clk);
        #1;
        d = rd_data_q;
        h = rd_hit_q;
    endtask : rd
endmodule : frrc_host
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; \
    $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module tb
    import frrc_pkg::*;
();
    logic clk = 1'b0, rst_b = 1'b0, stc = 1'b0, stc_run = 1'b1;
    logic wr_en, rd_hit_q, vin_en_out_q, vin_en_oe_n_q;
    logic [7:0] wr_cmd, rd_cmd, ov_fault, uv_fault, faulted_off, control_pin, operation_on;
    logic [7:0] retry_go_q, retry_exhausted_q, restart_hold_q;
    logic [15:0] wr_data, rd_data_q;
    int err_total, n_checks, cnt;
    always #5 clk = ~clk;
    // odd half period keeps the timebase drifting against clk
    always #20.3 if (stc_run) stc = ~stc;
    frrc_top #(.QUIET_LIMIT(5)) DUT (.clk, .rst_b, .shared_timebase_clock(stc), .wr_en,
        .wr_cmd, .wr_data, .rd_cmd, .rd_data_q, .rd_hit_q, .ov_fault, .uv_fault,
        .faulted_off, .control_pin, .operation_on, .vin_en_out_q, .vin_en_oe_n_q,
        .retry_go_q, .retry_exhausted_q, .restart_hold_q);
    frrc_host host (.clk, .rd_data_q, .rd_hit_q, .wr_en, .wr_cmd, .wr_data, .rd_cmd);
    function automatic logic [15:0] rb(input logic [7:0] c, input logic [15:0] d);
        case (c)
            CMD_OV_MASK, CMD_UV_MASK: return {8'h00, d[7:0]};
            CMD_RETRY_LIMIT: return {13'h0000, d[2:0]};
            CMD_RETRY_INTERVAL, CMD_RESTART_HOLD: return d;
            default: return 16'h0000;
        endcase
    endfunction : rb
    function automatic int l11u(input logic [15:0] v);
        real r;
        r = $signed(v[10:0]) * 5.0 * (2.0 ** $signed(v[15:11]));
        if (r < 0) r = 0;
        if (r > 65500) r = 65500;
        return int'(r);
    endfunction : l11u
    task automatic wg(input int ch, input int lim);
        for (cnt = 0; cnt < lim; cnt++) begin
            @(posedge clk);
            #1;
            if (retry_go_q[ch] || retry_exhausted_q[ch]) break;
        end
    endtask : wg
    task automatic fo(input int ch, input int lim);
        @(posedge clk) faulted_off <= 8'h01 << ch;
        @(posedge clk) faulted_off <= 8'h00;
        wg(ch, lim);
    endtask : fo
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    initial begin
        logic [7:0] cmds [6];
        logic [7:0] m [2];
        logic [15:0] d, rdv, ivl [3], hl [4];
        int offc [4], lims [3], i, j, ch, lim;
        logic h;
        cmds = '{CMD_OV_MASK, CMD_UV_MASK, CMD_RETRY_LIMIT, CMD_RETRY_INTERVAL,
            CMD_RESTART_HOLD, 8'h00};
        ivl = '{16'h0001, 16'hf007, 16'h07ff};
        hl = '{16'h0014, 16'h0001, 16'h0000, 16'h0014};
        offc = '{1100, 1100, 1100, 300};
        {ov_fault, uv_fault, faulted_off, operation_on} = 32'h00000000;
        control_pin = 8'hff;
        void'($urandom(49));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (i = 0; i < 6; i++) begin
            host.rd(cmds[i], d, h);
            `CHK("reset_val", 16'h0000, d)
            d = 16'($urandom);
            host.wr(cmds[i], d);
            host.rd(cmds[i], rdv, h);
            `CHK("readback", rb(cmds[i], d), rdv)
            `CHK("rd_hit", i < 5, h)
        end
        $display("test registers done");
        m[0] = 8'($urandom);
        m[1] = 8'($urandom);
        host.wr(CMD_OV_MASK, {8'h00, m[0]});
        host.wr(CMD_UV_MASK, {8'h00, m[1]});
        for (i = 0; i < 16; i++) begin
            @(posedge clk) {uv_fault, ov_fault} <= 16'h0001 << i;
            repeat (2) @(posedge clk);
            #1;
            `CHK("pull_n", ~m[i / 8][i % 8], vin_en_oe_n_q)
        end
        @(posedge clk) {uv_fault, ov_fault} <= 16'h0000;
        $display("test pulldown done");
        host.wr(CMD_RETRY_INTERVAL, 16'h0000);
        host.wr(CMD_RESTART_HOLD, 16'h0000);
        lims = '{$urandom_range(6, 1), 0, 7};
        for (j = 0; j < 3; j++) begin
            lim = lims[j];
            ch = $urandom_range(7);
            host.wr(CMD_RETRY_LIMIT, 16'(lim));
            @(posedge clk);
            #1;
            `CHK("clear_all", 8'h00, retry_exhausted_q)
            for (i = 0; i <= (lim == 7 ? 9 : lim); i++) begin
                fo(ch, 12);
                `CHK("retry_go", lim == 7 || i < lim, retry_go_q[ch])
            end
        end
        host.wr(CMD_RETRY_LIMIT, 16'h0001);
        fo(ch, 12);
        repeat (600) @(posedge clk);
        fo(ch, 12);
        `CHK("quiet_clear", 1'b1, retry_go_q[ch])
        fo(ch, 12);
        `CHK("exhausted", 1'b1, retry_exhausted_q[ch])
        @(posedge clk) operation_on[ch] <= 1'b1;
        fo(ch, 12);
        `CHK("op_clear", 1'b1, retry_go_q[ch])
        fo(ch, 12);
        @(posedge clk) control_pin[ch] <= 1'b0;
        repeat (20) @(posedge clk);
        control_pin[ch] <= 1'b1;
        repeat (10) @(posedge clk);
        fo(ch, 12);
        `CHK("ctl_clear", 1'b1, retry_go_q[ch])
        $display("test retry count done");
        host.wr(CMD_RETRY_LIMIT, 16'h0007);
        for (i = 0; i < 3; i++) begin
            host.wr(CMD_RETRY_INTERVAL, ivl[i]);
            lim = l11u(ivl[i]);
            fo(ch, 1200);
            `CHK("wait_span", 1'b1, cnt + 3 >= (lim - 1) * 81 && cnt <= lim * 82 + 12)
        end
        host.wr(CMD_RETRY_INTERVAL, 16'h0001);
        stc_run = 1'b0;
        fo(ch, 800);
        `CHK("no_tick_go", 1'b0, retry_go_q[ch])
        stc_run = 1'b1;
        wg(ch, 600);
        `CHK("tick_go", 1'b1, retry_go_q[ch])
        $display("test retry interval done");
        for (i = 0; i < 4; i++) begin
            host.wr(CMD_RESTART_HOLD, hl[i]);
            @(posedge clk) control_pin[ch] <= 1'b0;
            repeat (offc[i]) @(posedge clk);
            control_pin[ch] <= 1'b1;
            repeat (12) @(posedge clk);
            #1;
            `CHK("hold_start", i == 0, restart_hold_q[ch])
            if (i == 0) begin
                repeat (6000) @(posedge clk);
                #1;
                `CHK("hold_keep", 1'b1, restart_hold_q[ch])
                for (cnt = 0; cnt < 2500 && restart_hold_q[ch]; cnt++) begin
                    @(posedge clk);
                    #1;
                end
                `CHK("hold_span", 1'b1, cnt + 7112 >= 8019 && cnt < 2500)
            end
        end
        $display("test restart done");
        end_sim();
    end
    // about three and a half times the expected run length
    initial begin
        #500000;
        err_total++;
        end_sim();
    end
endmodule : tb
`default_nettype wire
